/* File: pcm_consts.vh */
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH

// Model-register indices.
`define PCM_IDX_CB_ADDR 32'hc0000106
`define PCM_IDX_FEAT_CFG 32'hc0000105

// Feature-configuration field positions.
`define PCM_CFG_ALLOW_LO 1
`define PCM_CFG_ALLOW_HI 6
`define PCM_CFG_FREE_RUN 29
`define PCM_CFG_STAMP 30
`define PCM_CFG_THR_IRQ 31
`define PCM_CFG_TAG_LO 32
`define PCM_CFG_TAG_HI 39
`define PCM_CFG_VEC_LO 40
`define PCM_CFG_VEC_HI 47

// Writable bits of the feature-configuration register; all others are reserved.
`define PCM_CFG_WMASK 64'h0000_ffff_e000_007e

// Reset values.
`define PCM_CFG_RESET 64'h0000_0000_0000_0000
`define PCM_CB_RESET 64'h0000_0000_0000_0000
`define PCM_RDATA_IDLE 64'h0000_0000_0000_0000

`endif

/* File: pcm_cfg_fields.v */
`timescale 1ns/1ns
`include "pcm_consts.vh"

module pcm_cfg_fields #(
    parameter STAMP_PRESENT = 1
) (
    core_clk,
    sys_rst,
    cfg,
    active,
    event_allow,
    free_running_mode_enable,
    stamp_counter_store_enable,
    threshold_irq_allow,
    core_tag,
    threshold_vector
);
    input wire core_clk;
    input wire sys_rst;
    input wire [63:0] cfg;
    input wire active;
    output reg [5:0] event_allow;
    output reg free_running_mode_enable;
    output reg stamp_counter_store_enable;
    output reg threshold_irq_allow;
    output reg [7:0] core_tag;
    output reg [7:0] threshold_vector;

    wire stamp_avail;

    assign stamp_avail = (STAMP_PRESENT != 0);

    // -------------------------------------------------------------------
    // Field decode, each enable gated by an active control block; core_tag and threshold_vector are not gated.
    // -------------------------------------------------------------------
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            event_allow <= 6'h00;
            free_running_mode_enable <= 1'b0;
            stamp_counter_store_enable <= 1'b0;
            threshold_irq_allow <= 1'b0;
            core_tag <= 8'h00;
            threshold_vector <= 8'h00;
        end else begin
            event_allow <= cfg[`PCM_CFG_ALLOW_HI:`PCM_CFG_ALLOW_LO] & {6{active}};
            free_running_mode_enable <= cfg[`PCM_CFG_FREE_RUN] & active;
            stamp_counter_store_enable <= cfg[`PCM_CFG_STAMP] & stamp_avail & active;
            threshold_irq_allow <= cfg[`PCM_CFG_THR_IRQ] & active;
            core_tag <= cfg[`PCM_CFG_TAG_HI:`PCM_CFG_TAG_LO];
            threshold_vector <= cfg[`PCM_CFG_VEC_HI:`PCM_CFG_VEC_LO];
        end
    end

endmodule // pcm_cfg_fields

/* File: pcm_profiler_msrs.v */
// Operation
// - Bit 29 permits free-running mode; clear forces synchronized mode.
// - Bit 30 stores stamp counter in event records when counter exists.
// - Bit 31 gates threshold interrupts; clear means none raised.
// - Bits 39:32 give the core tag copied into event records.
// - Bits 47:40 give threshold interrupt vector; software programs it validly.
// - Index C000_0106h holds the control block linear address.
// - Reading the address register only returns it, no side effects.
// - Non-zero write to address register faults and leaves it unchanged.
// - Writing zero disables profiling at once, discarding internal state unsaved.
// - Control block accesses use the stored linear address, no segment base.
// - Address register resets to zero, so profiling starts disabled.
// - Whole feature-configuration register resets to zero.
// - Bits 1 to 6 individually permit the six event kinds.
// - Profiler unavailable, instructions fault undefined, while mask bit 62 clear.
`timescale 1ns/1ns
`include "pcm_consts.vh"

module pcm_profiler_msrs #(
    parameter STAMP_PRESENT = 1
) (
    core_clk,
    sys_rst,
    msr_rd_req,
    msr_wr_req,
    msr_index,
    msr_wdata,
    msr_ack,
    msr_rdata,
    general_protection_fault,
    cb_load_req,
    cb_load_addr,
    profiler_avail_bit,
    profiler_instr_req,
    undefined_op_fault,
    profiler_active,
    state_discard,
    profile_control_block_addr,
    event_allow,
    free_running_mode_enable,
    stamp_counter_store_enable,
    threshold_exceeded,
    threshold_irq,
    threshold_vector,
    core_tag
);
    input wire core_clk;
    input wire sys_rst;
    input wire msr_rd_req;
    input wire msr_wr_req;
    input wire [31:0] msr_index;
    input wire [63:0] msr_wdata;
    output reg msr_ack;
    output reg [63:0] msr_rdata;
    output reg general_protection_fault;
    input wire cb_load_req;
    input wire [63:0] cb_load_addr;
    input wire profiler_avail_bit;
    input wire profiler_instr_req;
    output reg undefined_op_fault;
    output wire profiler_active;
    output reg state_discard;
    output reg [63:0] profile_control_block_addr;
    output wire [5:0] event_allow;
    output wire free_running_mode_enable;
    output wire stamp_counter_store_enable;
    input wire threshold_exceeded;
    output reg threshold_irq;
    output wire [7:0] threshold_vector;
    output wire [7:0] core_tag;

    reg [63:0] feat_cfg_r;
    reg [63:0] feat_cfg_nxt;
    reg [63:0] cb_addr_r;
    reg [63:0] cb_addr_nxt;
    reg [63:0] rdata_nxt;
    reg fault_nxt;
    reg discard_nxt;
    wire hit_cb;
    wire hit_cfg;
    wire any_req;
    wire rd_only;
    wire wr_cfg;
    wire wr_cb;
    wire wr_cb_zero;
    wire rd_cfg;
    wire rd_cb;
    wire unmapped;
    wire load_take;
    wire threshold_irq_allow;

    // -------------------------------------------------------------------
    // Request decode.
    // -------------------------------------------------------------------
    assign hit_cb = (msr_index == `PCM_IDX_CB_ADDR);
    assign hit_cfg = (msr_index == `PCM_IDX_FEAT_CFG);
    assign any_req = msr_rd_req | msr_wr_req;

    // A write raised together with a read wins; the read is then not served.
    assign rd_only = msr_rd_req & ~msr_wr_req;
    assign wr_cfg = msr_wr_req & hit_cfg;
    assign wr_cb = msr_wr_req & hit_cb;
    assign wr_cb_zero = wr_cb & (msr_wdata == `PCM_CB_RESET);
    assign rd_cfg = rd_only & hit_cfg;
    assign rd_cb = rd_only & hit_cb;
    assign unmapped = any_req & ~hit_cb & ~hit_cfg;

    // A register request in the same cycle wins, and the load is lost.
    assign load_take = cb_load_req & profiler_avail_bit & ~any_req;

    // Profiling runs only with a non-zero block address and the feature made available.
    assign profiler_active = profiler_avail_bit & (cb_addr_r != `PCM_CB_RESET);

    // -------------------------------------------------------------------
    // Feature-configuration register.
    // -------------------------------------------------------------------
    always @* begin
        feat_cfg_nxt = feat_cfg_r;
        if (wr_cfg) begin
            feat_cfg_nxt = msr_wdata & `PCM_CFG_WMASK;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            feat_cfg_r <= `PCM_CFG_RESET;
        end else begin
            feat_cfg_r <= feat_cfg_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Control-block address register.
    // -------------------------------------------------------------------
    // A non-zero write never reaches the register; only the load port sets an address.
    always @* begin
        cb_addr_nxt = cb_addr_r;
        if (wr_cb_zero) begin
            cb_addr_nxt = `PCM_CB_RESET;
        end else if (load_take) begin
            cb_addr_nxt = cb_load_addr;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cb_addr_r <= `PCM_CB_RESET;
            profile_control_block_addr <= `PCM_CB_RESET;
        end else begin
            cb_addr_r <= cb_addr_nxt;
            profile_control_block_addr <= cb_addr_r;
        end
    end

    // -------------------------------------------------------------------
    // Register-port response.
    // -------------------------------------------------------------------
    always @* begin
        rdata_nxt = msr_rdata;
        fault_nxt = 1'b0;
        discard_nxt = 1'b0;
        if (wr_cb) begin
            fault_nxt = ~wr_cb_zero;
            discard_nxt = wr_cb_zero;
        end
        if (rd_cfg) begin
            rdata_nxt = feat_cfg_r;
        end else if (rd_cb) begin
            rdata_nxt = cb_addr_r;
        end
        if (unmapped) begin
            fault_nxt = 1'b1;
            if (rd_only) begin
                rdata_nxt = `PCM_RDATA_IDLE;
            end
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            msr_ack <= 1'b0;
            msr_rdata <= `PCM_RDATA_IDLE;
            general_protection_fault <= 1'b0;
            state_discard <= 1'b0;
        end else begin
            msr_ack <= any_req;
            msr_rdata <= rdata_nxt;
            general_protection_fault <= fault_nxt;
            state_discard <= discard_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Fault and interrupt outputs.
    // -------------------------------------------------------------------
    // A zero write in the same cycle suppresses the interrupt, as the state is gone.
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            undefined_op_fault <= 1'b0;
            threshold_irq <= 1'b0;
        end else begin
            undefined_op_fault <= profiler_instr_req & ~profiler_avail_bit;
            threshold_irq <= threshold_exceeded & threshold_irq_allow & ~discard_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Field decode.
    // -------------------------------------------------------------------
    pcm_cfg_fields #(
        .STAMP_PRESENT(STAMP_PRESENT)
    ) u_fields (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .cfg(feat_cfg_r),
        .active(profiler_active),
        .event_allow(event_allow),
        .free_running_mode_enable(free_running_mode_enable),
        .stamp_counter_store_enable(stamp_counter_store_enable),
        .threshold_irq_allow(threshold_irq_allow),
        .core_tag(core_tag),
        .threshold_vector(threshold_vector)
    );

endmodule // pcm_profiler_msrs

/* File: pcm_profiler_msrs_assertions.sv */
`timescale 1ns/1ns
`include "pcm_consts.vh"
module pcm_msrs_checker (
    input wire core_clk, input wire sys_rst,
    input wire msr_rd_req, input wire msr_wr_req,
    input wire [31:0] msr_index, input wire [63:0] msr_wdata,
    input wire msr_ack, input wire general_protection_fault,
    input wire state_discard, input wire profiler_active,
    input wire profiler_avail_bit, input wire profiler_instr_req,
    input wire undefined_op_fault, input wire threshold_exceeded,
    input wire threshold_irq, input wire [5:0] event_allow,
    input wire free_running_mode_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire cb_wr = msr_wr_req && msr_index == `PCM_IDX_CB_ADDR;
    ack_follows_req_a: assert property (
        msr_ack == $past(msr_rd_req || msr_wr_req)) else $error("ack mismatch");
    nz_write_fault_a: assert property (
        cb_wr && msr_wdata != 64'h0 |=> general_protection_fault && !state_discard)
        else $error("nonzero write not refused");
    zero_write_stop_a: assert property (
        cb_wr && msr_wdata == 64'h0 |=> state_discard && !profiler_active)
        else $error("zero write did not stop");
    read_no_effect_a: assert property (
        msr_rd_req && !msr_wr_req && msr_index == `PCM_IDX_CB_ADDR
        |=> !state_discard && !general_protection_fault) else $error("read had effect");
    irq_cause_a: assert property (
        threshold_irq |-> $past(threshold_exceeded)) else $error("irq without cause");
    undef_fault_a: assert property (
        undefined_op_fault == $past(profiler_instr_req && !profiler_avail_bit))
        else $error("undefined fault mismatch");
    active_needs_avail_a: assert property (
        profiler_active |-> profiler_avail_bit) else $error("active while unavailable");
    fields_gated_a: assert property (
        !$past(profiler_active) |-> event_allow == 6'h00 && !free_running_mode_enable)
        else $error("fields not gated");
endmodule // pcm_msrs_checker

bind pcm_profiler_msrs pcm_msrs_checker u_chk (.core_clk, .sys_rst, .msr_rd_req,
    .msr_wr_req, .msr_index, .msr_wdata, .msr_ack, .general_protection_fault,
    .state_discard, .profiler_active, .profiler_avail_bit, .profiler_instr_req,
    .undefined_op_fault, .threshold_exceeded, .threshold_irq, .event_allow,
    .free_running_mode_enable);

/* File: test_profiler_control_msrs.sv */
`timescale 1ns/1ns
`include "pcm_consts.vh"
module test_profiler_control_msrs;
    logic core_clk = 0, sys_rst = 1, msr_rd_req = 0, msr_wr_req = 0, cb_load_req = 0;
    logic profiler_avail_bit = 1, profiler_instr_req = 0, threshold_exceeded = 0;
    logic [31:0] msr_index = 32'h0;
    logic [63:0] msr_wdata = 64'h0, cb_load_addr = 64'h0, msr_rdata, q;
    logic [63:0] profile_control_block_addr;
    logic msr_ack, general_protection_fault, undefined_op_fault, profiler_active, f;
    logic state_discard, threshold_irq, free_running_mode_enable, stamp_counter_store_enable;
    logic [5:0] event_allow;
    logic [7:0] threshold_vector, core_tag;
    int err_count = 0, checked = 0, cycles = 0;
    always #4 core_clk = ~core_clk;
    pcm_profiler_msrs dut (.core_clk, .sys_rst, .msr_rd_req, .msr_wr_req, .msr_index,
        .msr_wdata, .msr_ack, .msr_rdata, .general_protection_fault, .cb_load_req,
        .cb_load_addr, .profiler_avail_bit, .profiler_instr_req, .undefined_op_fault,
        .profiler_active, .state_discard, .profile_control_block_addr, .event_allow,
        .free_running_mode_enable, .stamp_counter_store_enable, .threshold_exceeded,
        .threshold_irq, .threshold_vector, .core_tag);
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            final_report();
        end
    end
    // Holds one request across its taking edge, then samples the answer.
    task automatic acc(input logic wr, input logic [31:0] idx, input logic [63:0] d);
        @(posedge core_clk) #1;
        {msr_wr_req, msr_rd_req, msr_index, msr_wdata} = {wr, !wr, idx, d};
        @(posedge core_clk) #1;
        {msr_wr_req, msr_rd_req} = 2'b00;
        chk(msr_ack, 1'b1);
        q = msr_rdata;
        f = general_protection_fault;
    endtask
    task automatic pulse_thr(input logic exp);
        @(posedge core_clk) #1 threshold_exceeded = 1;
        @(posedge core_clk) #1 threshold_exceeded = 0;
        chk(threshold_irq, exp);
    endtask
    task automatic t_reset_and_cfg();
        acc(0, `PCM_IDX_FEAT_CFG, 0); chk(q, `PCM_CFG_RESET);
        acc(0, `PCM_IDX_CB_ADDR, 0); chk(q, 64'h0);
        chk(profiler_active, 1'b0);
        acc(1, `PCM_IDX_FEAT_CFG, 64'hffff_ffff_ffff_ffff); chk(f, 1'b0);
        acc(0, `PCM_IDX_FEAT_CFG, 0); chk(q, `PCM_CFG_WMASK);
        acc(0, 32'hc000_0107, 0); chk(f, 1'b1);
    endtask
    task automatic t_refuse_then_load();
        acc(1, `PCM_IDX_CB_ADDR, 64'h0000_0000_0000_1000); chk(f, 1'b1);
        acc(0, `PCM_IDX_CB_ADDR, 0); chk(q, 64'h0);
        @(posedge core_clk) #1 {cb_load_req, cb_load_addr} = {1'b1, 64'h0000_7fff_1234_5000};
        @(posedge core_clk) #1 cb_load_req = 0;
        chk(profiler_active, 1'b1);
        @(posedge core_clk) #1 chk(profile_control_block_addr, 64'h0000_7fff_1234_5000);
        chk({event_allow, free_running_mode_enable}, 7'h7f);
        chk({stamp_counter_store_enable, core_tag, threshold_vector}, 17'h1ffff);
        acc(0, `PCM_IDX_CB_ADDR, 0); chk(q, 64'h0000_7fff_1234_5000);
        chk(state_discard, 1'b0);
    endtask
    task automatic t_irq_and_stop();
        pulse_thr(1'b1);
        acc(1, `PCM_IDX_FEAT_CFG, 64'hdead_c35a_2000_0054);
        @(posedge core_clk) #1 chk({event_allow, free_running_mode_enable}, 7'h55);
        chk({stamp_counter_store_enable, core_tag, threshold_vector}, 17'h05ac3);
        acc(0, `PCM_IDX_FEAT_CFG, 0);
        chk(q, 64'h0000_c35a_2000_0054);
        pulse_thr(1'b0);
        acc(1, `PCM_IDX_CB_ADDR, 64'h0); chk(f, 1'b0);
        chk({state_discard, profiler_active}, 2'b10);
        @(posedge core_clk) #1 chk(event_allow, 6'h00);
        profiler_avail_bit = 0;
        @(posedge core_clk) #1 profiler_instr_req = 1;
        @(posedge core_clk) #1 profiler_instr_req = 0;
        chk(undefined_op_fault, 1'b1);
        @(posedge core_clk) #1 {cb_load_req, cb_load_addr} = {1'b1, 64'h0000_0000_0000_2000};
        @(posedge core_clk) #1 cb_load_req = 0;
        profiler_avail_bit = 1;
        acc(0, `PCM_IDX_CB_ADDR, 0);
        chk(q, 64'h0);
        chk(profiler_active, 1'b0);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        #1 sys_rst = 0;
        t_reset_and_cfg();
        t_refuse_then_load();
        t_irq_and_stop();
        final_report();
    end
endmodule // test_profiler_control_msrs
